// [hw/vsu_defs.svh]
// Purpose: Register map, field positions and reset values of the voltage statistics unit.
// Assumes: APB with 32-bit data, byte addresses, one aligned word per register.
// Notes: Included by the top module by its bare name.
`ifndef VSU_DEFS_SVH
`define VSU_DEFS_SVH

`define VSU_OFF_CTRL      12'h000
`define VSU_OFF_CMD       12'h004
`define VSU_OFF_DURATION  12'h008
`define VSU_OFF_CUTOFF    12'h00c
`define VSU_OFF_REFMIN    12'h010
`define VSU_OFF_GAIN_PRI  12'h014
`define VSU_OFF_GAIN_SEC  12'h018
`define VSU_OFF_STATUS    12'h01c
`define VSU_CH_BASE       12'h040
`define VSU_CH_SHIFT      5
`define VSU_ITEM_MIN      3'h0
`define VSU_ITEM_MAX      3'h1
`define VSU_ITEM_AVG      3'h2
`define VSU_ITEM_DISP     3'h3
`define VSU_ITEM_ANGLE    3'h4

`define VSU_CTRL_SLIDING  0
`define VSU_CTRL_TRIGGER  1
`define VSU_CTRL_SCALE_LO 2
`define VSU_CTRL_SCALE_HI 3
`define VSU_CTRL_WIDTH    4
`define VSU_CMD_CLEAR     0
`define VSU_STAT_ARMED    8

`define VSU_RST_CTRL      4'h0
`define VSU_RST_DURATION  16'h000a
`define VSU_RST_CUTOFF    16'h0000
`define VSU_RST_REFMIN    16'h0010
`define VSU_RST_GAIN      16'h0100
`define VSU_GAIN_SHIFT    8

`endif

// [hw/vsu_pkg.sv]
// Purpose: Types shared by the voltage statistics unit.
// Assumes: Nothing beyond the defines header.
// Notes: Scaling codes map 0 per-unit, 1 primary, 2 secondary; 3 falls back to per-unit.
package vsu_pkg;
    typedef enum logic [1:0] {VSU_AVG_FIXED, VSU_AVG_SLIDING, VSU_AVG_TRIGGER} vsu_avg_mode_e;
    typedef enum logic [1:0] {VSU_SCALE_PU, VSU_SCALE_PRI, VSU_SCALE_SEC} vsu_scale_e;
endpackage

// [hw/vsu_top.sv]
// Purpose: Min/max, average, cutoff, scaling and phase-angle conditioning of voltages.
// Assumes: One sample set per sample_valid pulse; inputs synchronous to pclk.
// Notes: APB answers with no wait state; read data is captured in the setup cycle.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "vsu_defs.svh"

module vsu_top #(
    parameter int NCH   = 3,
    parameter int W     = 16,
    parameter int AW    = 16,
    parameter int DEPTH = 16,
    parameter int CW    = 16
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Measured quantities
    input  wire logic                   sample_valid,
    input  wire logic [NCH-1:0][W-1:0]  sample_mag,
    input  wire logic [NCH-1:0][AW-1:0] sample_ang,
    // Assignable digital signals
    input  wire logic                   minimum_reset_source,
    input  wire logic                   maximum_reset_source,
    input  wire logic                   average_trigger_signal,
    input  wire logic                   average_reset_source,
    // Recorder side and status
    output logic      [NCH-1:0][W-1:0]  rec_mag,
    output logic      [$clog2(NCH)-1:0] ref_channel
);
    localparam int LD   = $clog2(DEPTH);
    localparam int RW   = $clog2(NCH);
    localparam int ACCW = W + CW;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    generate
        if (NCH < 2 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || LD >= CW || W > 32
            || AW > 32 || CW > 16) begin : g_bad_params
            $error("vsu_top: unsupported parameter values");
        end
    endgenerate

    // Configuration and bus state.
    logic [`VSU_CTRL_WIDTH-1:0] ctrl, next_ctrl;
    logic [15:0]                duration, next_duration;
    logic [15:0]                cutoff, next_cutoff;
    logic [15:0]                refmin, next_refmin;
    logic [15:0]                gain_pri, next_gain_pri;
    logic [15:0]                gain_sec, next_gain_sec;
    logic [31:0]                next_prdata;
    logic                       next_pslverr;
    logic                       wr_en;
    logic                       cfg_chg;
    logic                       clr_cmd;

    // Statistics state.
    logic [NCH-1:0][W-1:0]      vmin, next_vmin;
    logic [NCH-1:0][W-1:0]      vmax, next_vmax;
    logic [NCH-1:0][ACCW-1:0]   acc, next_acc;
    logic [NCH-1:0][W-1:0]      avg, next_avg;
    logic [NCH-1:0][W-1:0]      disp, next_disp;
    logic [NCH-1:0][AW-1:0]     angle, next_angle;
    logic [NCH-1:0][W-1:0]      next_rec;
    logic [W-1:0]               hist [NCH][DEPTH];
    logic [W-1:0]               next_hist [NCH][DEPTH];
    logic [CW-1:0]              cnt, next_cnt;
    logic [LD-1:0]              wptr, next_wptr;
    logic                       armed, next_armed;
    logic [RW-1:0]              next_ref;
    logic [3:0]                 prev_in, next_prev_in;

    assign pready = 1'b1;

    // Bus decode and configuration.
    always_comb begin
        logic [11:0] rel;
        logic [RW:0] ch;
        logic [2:0]  item;
        logic        rd_ok;
        logic        wr_ok;
        rel           = paddr - `VSU_CH_BASE;
        ch            = (RW + 1)'(rel >> `VSU_CH_SHIFT);
        item          = rel[4:2];
        rd_ok         = 1'b1;
        wr_ok         = 1'b1;
        next_ctrl     = ctrl;
        next_duration = duration;
        next_cutoff   = cutoff;
        next_refmin   = refmin;
        next_gain_pri = gain_pri;
        next_gain_sec = gain_sec;
        next_prdata   = prdata;
        next_pslverr  = pslverr;
        wr_en         = psel && penable && pready && pwrite;
        cfg_chg       = 1'b0;
        clr_cmd       = 1'b0;
        if (wr_en) begin
            if (paddr == `VSU_OFF_CTRL) begin
                next_ctrl = pwdata[`VSU_CTRL_WIDTH-1:0];
                cfg_chg   = 1'b1;
            end else if (paddr == `VSU_OFF_CMD) begin
                clr_cmd = pwdata[`VSU_CMD_CLEAR];
            end else if (paddr == `VSU_OFF_DURATION) begin
                next_duration = pwdata[15:0];
                cfg_chg       = 1'b1;
            end else if (paddr == `VSU_OFF_CUTOFF) begin
                next_cutoff = pwdata[15:0];
                cfg_chg     = 1'b1;
            end else if (paddr == `VSU_OFF_REFMIN) begin
                next_refmin = pwdata[15:0];
                cfg_chg     = 1'b1;
            end else if (paddr == `VSU_OFF_GAIN_PRI) begin
                next_gain_pri = pwdata[15:0];
                cfg_chg       = 1'b1;
            end else if (paddr == `VSU_OFF_GAIN_SEC) begin
                next_gain_sec = pwdata[15:0];
                cfg_chg       = 1'b1;
            end
        end
        // Read data and the error answer are settled in the setup cycle so that
        // the access cycle can complete at once from flip-flops.
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            if (paddr == `VSU_OFF_CTRL) begin
                next_prdata[`VSU_CTRL_WIDTH-1:0] = ctrl;
            end else if (paddr == `VSU_OFF_CMD) begin
                next_prdata = 32'h0000_0000;
            end else if (paddr == `VSU_OFF_DURATION) begin
                next_prdata[15:0] = duration;
            end else if (paddr == `VSU_OFF_CUTOFF) begin
                next_prdata[15:0] = cutoff;
            end else if (paddr == `VSU_OFF_REFMIN) begin
                next_prdata[15:0] = refmin;
            end else if (paddr == `VSU_OFF_GAIN_PRI) begin
                next_prdata[15:0] = gain_pri;
            end else if (paddr == `VSU_OFF_GAIN_SEC) begin
                next_prdata[15:0] = gain_sec;
            end else if (paddr == `VSU_OFF_STATUS) begin
                next_prdata[RW-1:0]           = ref_channel;
                next_prdata[`VSU_STAT_ARMED]  = armed;
                wr_ok                         = 1'b0;
            end else if (paddr >= `VSU_CH_BASE && ch < (RW + 1)'(NCH)
                         && paddr[1:0] == 2'h0 && item <= `VSU_ITEM_ANGLE) begin
                wr_ok = 1'b0;
                if (item == `VSU_ITEM_MIN) begin
                    next_prdata[W-1:0] = vmin[ch[RW-1:0]];
                end else if (item == `VSU_ITEM_MAX) begin
                    next_prdata[W-1:0] = vmax[ch[RW-1:0]];
                end else if (item == `VSU_ITEM_AVG) begin
                    next_prdata[W-1:0] = avg[ch[RW-1:0]];
                end else if (item == `VSU_ITEM_DISP) begin
                    next_prdata[W-1:0] = disp[ch[RW-1:0]];
                end else begin
                    next_prdata[AW-1:0] = angle[ch[RW-1:0]];
                end
            end else begin
                rd_ok = 1'b0;
                wr_ok = 1'b0;
            end
            next_pslverr = pwrite ? !wr_ok : !rd_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `VSU_RST_CTRL;
            duration <= `VSU_RST_DURATION;
            cutoff   <= `VSU_RST_CUTOFF;
            refmin   <= `VSU_RST_REFMIN;
            gain_pri <= `VSU_RST_GAIN;
            gain_sec <= `VSU_RST_GAIN;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            duration <= next_duration;
            cutoff   <= next_cutoff;
            refmin   <= next_refmin;
            gain_pri <= next_gain_pri;
            gain_sec <= next_gain_sec;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
        end
    end

    // Statistics, display conditioning and phase angles.
    always_comb begin
        vsu_pkg::vsu_avg_mode_e mode;
        vsu_pkg::vsu_scale_e    scale;
        logic [CW-1:0]          eff;
        logic [CW-1:0]          n;
        logic [ACCW-1:0]        sum;
        logic [W-1:0]           old;
        logic [W-1:0]           base;
        logic [W+15:0]          prod;
        logic                   min_edge;
        logic                   max_edge;
        logic                   trig_edge;
        logic                   avg_clr;
        logic                   full;
        logic                   found;
        mode         = vsu_pkg::VSU_AVG_FIXED;
        scale        = vsu_pkg::VSU_SCALE_PU;
        eff          = (duration == 16'h0000) ? CW'(1) : CW'(duration);
        n            = eff;
        sum          = '0;
        old          = '0;
        base         = '0;
        prod         = '0;
        found        = 1'b0;
        next_prev_in = {minimum_reset_source, maximum_reset_source,
                        average_trigger_signal, average_reset_source};
        min_edge     = minimum_reset_source && !prev_in[3];
        max_edge     = maximum_reset_source && !prev_in[2];
        trig_edge    = average_trigger_signal && !prev_in[1];
        avg_clr      = clr_cmd || (average_reset_source && !prev_in[0]) || cfg_chg;
        if (ctrl[`VSU_CTRL_TRIGGER]) begin
            mode = vsu_pkg::VSU_AVG_TRIGGER;
        end else if (ctrl[`VSU_CTRL_SLIDING]) begin
            mode = vsu_pkg::VSU_AVG_SLIDING;
            if (eff > DEPTH_C) begin
                eff = DEPTH_C;
            end
        end
        if (ctrl[`VSU_CTRL_SCALE_HI:`VSU_CTRL_SCALE_LO] == 2'h1) begin
            scale = vsu_pkg::VSU_SCALE_PRI;
        end else if (ctrl[`VSU_CTRL_SCALE_HI:`VSU_CTRL_SCALE_LO] == 2'h2) begin
            scale = vsu_pkg::VSU_SCALE_SEC;
        end
        full       = (cnt >= eff);
        next_vmin  = vmin;
        next_vmax  = vmax;
        next_acc   = acc;
        next_avg   = avg;
        next_disp  = disp;
        next_angle = angle;
        next_rec   = rec_mag;
        next_hist  = hist;
        next_cnt   = cnt;
        next_wptr  = wptr;
        next_armed = armed;
        next_ref   = ref_channel;
        // the lowest-numbered channel with enough amplitude is the reference.
        for (int i = NCH - 1; i >= 0; i--) begin
            if (sample_mag[i] >= W'(refmin)) begin
                next_ref = RW'(i);
                found    = 1'b1;
            end
        end
        if (!sample_valid || !found) begin
            next_ref = ref_channel;
        end
        for (int i = 0; i < NCH; i++) begin
            // Restart loads the neutral value so the next sample takes over at once.
            base = (min_edge || cfg_chg) ? '1 : vmin[i];
            next_vmin[i] = (sample_valid && sample_mag[i] < base) ? sample_mag[i] : base;
            base = (max_edge || cfg_chg) ? '0 : vmax[i];
            next_vmax[i] = (sample_valid && sample_mag[i] > base) ? sample_mag[i] : base;
            if (sample_valid) begin
                next_rec[i]             = sample_mag[i];
                next_hist[i][wptr]      = sample_mag[i];
                if (scale == vsu_pkg::VSU_SCALE_PRI) begin
                    prod = (W + 16)'(sample_mag[i] * gain_pri) >> `VSU_GAIN_SHIFT;
                end else if (scale == vsu_pkg::VSU_SCALE_SEC) begin
                    prod = (W + 16)'(sample_mag[i] * gain_sec) >> `VSU_GAIN_SHIFT;
                end else begin
                    prod = (W + 16)'(sample_mag[i]);
                end
                next_disp[i]  = (sample_mag[i] < W'(cutoff)) ? '0 : prod[W-1:0];
                next_angle[i] = (RW'(i) == next_ref) ? '0
                                : sample_ang[i] - sample_ang[next_ref];
            end
            if (avg_clr) begin
                next_acc[i] = '0;
                next_avg[i] = '0;
            end else if (mode == vsu_pkg::VSU_AVG_TRIGGER) begin
                sum = sample_valid ? ACCW'(sample_mag[i]) : '0;
                if (trig_edge) begin
                    if (armed && cnt != '0) begin
                        next_avg[i] = W'(acc[i] / ACCW'(cnt));
                    end
                    next_acc[i] = sum;
                end else begin
                    next_acc[i] = acc[i] + sum;
                end
            end else if (sample_valid && mode == vsu_pkg::VSU_AVG_SLIDING) begin
                old         = full ? hist[i][wptr - LD'(eff)] : '0;
                sum         = acc[i] + ACCW'(sample_mag[i]) - ACCW'(old);
                n           = full ? eff : cnt + CW'(1);
                next_acc[i] = sum;
                next_avg[i] = W'(sum / ACCW'(n));
            end else if (sample_valid) begin
                sum = acc[i] + ACCW'(sample_mag[i]);
                if (cnt + CW'(1) >= eff) begin
                    next_avg[i] = W'(sum / ACCW'(eff));
                    next_acc[i] = '0;
                end else begin
                    next_acc[i] = sum;
                end
            end
        end
        if (sample_valid) begin
            next_wptr = wptr + LD'(1);
        end
        if (avg_clr) begin
            next_cnt   = '0;
            // A trigger edge that meets a clear still arms, so its interval is not lost.
            next_armed = trig_edge && mode == vsu_pkg::VSU_AVG_TRIGGER;
        end else if (mode == vsu_pkg::VSU_AVG_TRIGGER) begin
            if (trig_edge) begin
                next_cnt   = sample_valid ? CW'(1) : '0;
                next_armed = 1'b1;
            end else if (sample_valid && cnt != '1) begin
                next_cnt = cnt + CW'(1);
            end
        end else if (sample_valid && mode == vsu_pkg::VSU_AVG_SLIDING) begin
            next_cnt = full ? cnt : cnt + CW'(1);
        end else if (sample_valid) begin
            next_cnt = (cnt + CW'(1) >= eff) ? '0 : cnt + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vmin        <= '1;
            vmax        <= '0;
            acc         <= '0;
            avg         <= '0;
            disp        <= '0;
            angle       <= '0;
            rec_mag     <= '0;
            hist        <= '{default: '{default: '0}};
            cnt         <= '0;
            wptr        <= '0;
            armed       <= 1'b0;
            ref_channel <= '0;
            prev_in     <= 4'h0;
        end else begin
            vmin        <= next_vmin;
            vmax        <= next_vmax;
            acc         <= next_acc;
            avg         <= next_avg;
            disp        <= next_disp;
            angle       <= next_angle;
            rec_mag     <= next_rec;
            hist        <= next_hist;
            cnt         <= next_cnt;
            wptr        <= next_wptr;
            armed       <= next_armed;
            ref_channel <= next_ref;
            prev_in     <= next_prev_in;
        end
    end
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the voltage statistics unit.
// Assumes: APB master waits for pready; samples and signals come from the model.
// Notes: Each scenario task drives the unit and judges what it reads back.
`timescale 1ns/1ps
`include "vsu_defs.svh"
module tb_top;
    logic             pclk;
    logic             presetn;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             sample_valid;
    logic [2:0][15:0] sample_mag;
    logic [2:0][15:0] sample_ang;
    logic [3:0]       sig;
    logic [2:0][15:0] rec_mag;
    logic [1:0]       ref_channel;
    int               errors;
    int               comparisons;

    vsu_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sample_valid, .sample_mag, .sample_ang,
        .minimum_reset_source(sig[0]), .maximum_reset_source(sig[1]),
        .average_trigger_signal(sig[2]), .average_reset_source(sig[3]),
        .rec_mag, .ref_channel);
    vsu_meas_model m (.pclk, .sample_valid, .sample_mag, .sample_ang, .sig);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("BAD t=%0t pready=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask

    function automatic logic [11:0] ca(input int c, input int k);
        return `VSU_CH_BASE + 12'(c * 32 + k * 4);
    endfunction

    task automatic smp(input logic [15:0] m0);
        m.send({16'h40, 16'h40, m0}, '0);
    endtask

    task automatic s_reset;
        logic [31:0] r;
        logic        e;
        rc(`VSU_OFF_CTRL, 32'h0);
        rc(`VSU_OFF_DURATION, 32'ha);
        rc(`VSU_OFF_REFMIN, 32'h10);
        rc(`VSU_OFF_GAIN_PRI, 32'h100);
        rc(`VSU_OFF_CMD, 32'h0);
        rc(ca(0, 0), 32'hffff);
        rc(ca(0, 1), 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, `VSU_OFF_STATUS, 32'h3, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic s_minmax;
        wr(`VSU_OFF_CUTOFF, 32'h0);
        smp(16'h50);
        smp(16'h30);
        smp(16'h70);
        rc(ca(0, 0), 32'h30);
        rc(ca(0, 1), 32'h70);
        m.pulse(0);
        rc(ca(0, 0), 32'hffff);
        rc(ca(0, 1), 32'h70);
        m.pulse(1);
        rc(ca(0, 1), 32'h0);
        smp(16'h44);
        rc(ca(0, 0), 32'h44);
        wr(`VSU_OFF_CUTOFF, 32'h0);
        rc(ca(0, 0), 32'hffff);
        rc(ca(0, 1), 32'h0);
    endtask

    task automatic s_fixed;
        wr(`VSU_OFF_DURATION, 32'h2);
        smp(16'h0a);
        smp(16'h15);
        rc(ca(0, 2), 32'hf);
        smp(16'h28);
        rc(ca(0, 2), 32'hf);
        smp(16'h32);
        rc(ca(0, 2), 32'h2d);
    endtask

    task automatic s_slide;
        wr(`VSU_OFF_CTRL, 32'h1);
        smp(16'h0a);
        smp(16'h14);
        rc(ca(0, 2), 32'hf);
        smp(16'h28);
        rc(ca(0, 2), 32'h1e);
        wr(`VSU_OFF_CMD, 32'h1);
        rc(ca(0, 2), 32'h0);
        smp(16'h3c);
        rc(ca(0, 2), 32'h3c);
        m.pulse(3);
        rc(ca(0, 2), 32'h0);
    endtask

    task automatic s_trig;
        wr(`VSU_OFF_CTRL, 32'h2);
        m.pulse(2);
        smp(16'h08);
        smp(16'h10);
        m.pulse(2);
        rc(ca(0, 2), 32'hc);
    endtask

    // Channel 0 stays below the cutoff in every scaling, so the zero does not hinge on order.
    task automatic s_disp;
        logic [31:0] x[4];
        x = '{32'h80, 32'h100, 32'h40, 32'h80};
        wr(`VSU_OFF_GAIN_PRI, 32'h200);
        wr(`VSU_OFF_GAIN_SEC, 32'h80);
        wr(`VSU_OFF_CUTOFF, 32'h20);
        for (int k = 0; k < 4; k++) begin
            wr(`VSU_OFF_CTRL, 32'(k << 2));
            m.send({16'h80, 16'h80, 16'h08}, '0);
            rc(ca(1, 3), x[k]);
            rc(ca(0, 3), 32'h0);
            chk({16'h0, rec_mag[0]}, 32'h8);
        end
    endtask

    task automatic s_phase;
        wr(`VSU_OFF_CTRL, 32'h0);
        m.send({16'h100, 16'h100, 16'h100}, {16'h0800, 16'h3000, 16'h1000});
        rc(ca(0, 4), 32'h0);
        rc(ca(1, 4), 32'h2000);
        rc(ca(2, 4), 32'hf800);
        m.send({16'h100, 16'h100, 16'h08}, {16'h0800, 16'h3000, 16'h1000});
        @(negedge pclk);
        chk({30'h0, ref_channel}, 32'h1);
        rc(ca(1, 4), 32'h0);
        rc(ca(0, 4), 32'he000);
        m.send({16'h100, 16'h100, 16'hffff}, '0);
        @(negedge pclk);
        chk({30'h0, ref_channel}, 32'h0);
    endtask

    task automatic tally_and_finish;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        #500000;
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_minmax();
        s_fixed();
        s_slide();
        s_trig();
        s_disp();
        s_phase();
        tally_and_finish();
    end
endmodule

bind vsu_top vsu_assertions #(.NCH(NCH), .W(W), .AW(AW)) chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid,
    .sample_mag, .sample_ang, .minimum_reset_source, .maximum_reset_source,
    .average_trigger_signal, .average_reset_source, .rec_mag, .ref_channel);

// [testbench/vsu_assertions.sv]
// Purpose: Port-level checks of the voltage statistics unit.
// Assumes: Bound to vsu_top; one clock domain with asynchronous active-low reset.
// Notes: Register contents are judged by the bench; these watch timing and the recorder side.
`timescale 1ns/1ps
`include "vsu_defs.svh"
module vsu_assertions #(
    parameter int NCH = 3,
    parameter int W   = 16,
    parameter int AW  = 16
) (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB slave
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Measured quantities
    input wire logic                   sample_valid,
    input wire logic [NCH-1:0][W-1:0]  sample_mag,
    input wire logic [NCH-1:0][AW-1:0] sample_ang,
    // Assignable digital signals
    input wire logic                   minimum_reset_source,
    input wire logic                   maximum_reset_source,
    input wire logic                   average_trigger_signal,
    input wire logic                   average_reset_source,
    // Recorder side and status
    input wire logic [NCH-1:0][W-1:0]  rec_mag,
    input wire logic [$clog2(NCH)-1:0] ref_channel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_high_a: assert property (pready) else $error("pready not high");
    prdata_stands_a: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved after access");
    cmd_reads_zero_a: assert property (psel && !penable && !pwrite && paddr == `VSU_OFF_CMD
        |=> prdata == 32'h0 && !pslverr) else $error("command register not read as zero");
    unmapped_err_a: assert property (psel && !penable && paddr == 12'h020 |=> pslverr)
        else $error("unmapped access without error");
    status_ro_a: assert property (psel && !penable && pwrite && paddr == `VSU_OFF_STATUS
        |=> pslverr) else $error("status write without error");
    rec_follow_a: assert property (sample_valid |=> rec_mag == $past(sample_mag))
        else $error("recorded magnitude differs from sample");
    rec_hold_a: assert property (!sample_valid |=> $stable(rec_mag))
        else $error("recorded magnitude moved without sample");
    ref_hold_a: assert property (!sample_valid |=> $stable(ref_channel))
        else $error("reference moved without sample");
    ref_first_a: assert property (sample_valid && sample_mag[0] == {W{1'b1}}
        |=> ref_channel == '0) else $error("first channel not taken as reference");
    ref_range_a: assert property (ref_channel < NCH) else $error("reference out of range");

    cover property (psel && penable && pslverr);
    cover property ($changed(ref_channel));
    cover property (sample_valid && sample_mag[0] < 16'h10);
endmodule

// [testbench/vsu_meas_model.sv]
// Purpose: Measurement channels and assignable digital signals feeding the unit.
// Assumes: Driven right after rising pclk edges by non-blocking assignment.
// Notes: After each valid cycle the sample lines carry inverted data, so stale use shows.
`timescale 1ns/1ps
module vsu_meas_model (
    // Clock
    input  wire logic        pclk,
    // Samples and signals
    output logic             sample_valid,
    output logic [2:0][15:0] sample_mag,
    output logic [2:0][15:0] sample_ang,
    output logic [3:0]       sig
);
    initial begin
        sample_valid = 1'b0;
        sample_mag = '0;
        sample_ang = '0;
        sig = '0;
    end

    task automatic send(input logic [2:0][15:0] m, input logic [2:0][15:0] a);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_mag <= m;
        sample_ang <= a;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_mag <= ~m;
        sample_ang <= ~a;
    endtask

    // Held two cycles so the unit sees one clean rising edge.
    task automatic pulse(input int i);
        @(posedge pclk);
        sig[i] <= 1'b1;
        repeat (2) @(posedge pclk);
        sig[i] <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
